/* File: logic/aau_adder.sv */
// 32-bit adder core with carry in, carry out and signed overflow
`timescale 1ns/1ps
module aau_adder
  import aau_pkg::*;
(
  input  wire aau_pkg::aau_word_t a,
  input  wire aau_pkg::aau_word_t b,
  input  wire logic               cin,
  output aau_pkg::aau_word_t      sum,
  output logic                    carry_out,
  output logic                    overflow
);
  logic [DATA_W:0] wide;

  always_comb
  begin
    wide      = {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, cin};
    sum       = wide[DATA_W-1:0];
    carry_out = wide[DATA_W];
    // Like-signed operands giving an opposite-signed sum
    overflow  = (a[DATA_W-1] == b[DATA_W-1]) && (wide[DATA_W-1] != a[DATA_W-1]);
  end
endmodule : aau_adder

/* File: logic/aau_pkg.sv */
// Shared constants and types for the absolute and signed add unit
package aau_pkg;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned IMM_W      = 9;
  localparam int unsigned REG_IDX_W  = 9;
  localparam int unsigned OP_CYCLES  = 4;
  localparam logic [31:0] RST_DATA   = 32'h0000_0000;
  localparam logic        RST_ZERO   = 1'b0;
  localparam logic        RST_CARRY  = 1'b0;
  localparam logic [8:0]  RST_INDEX  = 9'h000;

  typedef logic [DATA_W-1:0]    aau_word_t;
  typedef logic [IMM_W-1:0]     aau_imm_t;
  typedef logic [REG_IDX_W-1:0] aau_idx_t;

  typedef enum logic [1:0] {
    AAU_OP_MAGNITUDE,
    AAU_OP_SIGNED,
    AAU_OP_SIGNED_CARRY
  } aau_op_e;

  typedef enum logic [1:0] {
    AAU_ST_IDLE,
    AAU_ST_FETCH,
    AAU_ST_ADD,
    AAU_ST_COMMIT
  } aau_state_e;
endpackage : aau_pkg

/* File: logic/aau_unit.sv */
// Absolute and signed add unit: three add operations, flags and writeback
// Behaviour
// - Magnitude add: destination plus absolute value of source, written to destination.
// - Source comes from a register or a 9-bit immediate literal.
// - Immediate source is zero-extended to 32 bits, never negative.
// - Magnitude add treats the destination as unsigned; only source is signed.
// - Magnitude add with zero update: zero flag set when sum wraps to zero.
// - Magnitude add, non-negative source: carry takes unsigned carry out.
// - Magnitude add, negative source: carry derived from borrow of destination minus source.
// - Signed add: two's-complement sum written to destination.
// - Signed add with zero update: zero flag set iff sum is zero.
// - Signed add with carry update: carry flag reports signed overflow.
// - Signed add with carry: destination plus source plus carry flag.
// - Sum written back unless suppressed; flags still update when suppressed.
// - Destination field names first operand and result register.
// - Signed carry add zero update: zero only if already zero and sum zero.
// - Signed carry add carry update: carry reports signed overflow.
`timescale 1ns/1ps
module aau_unit
  import aau_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               nrst,
  input  wire logic               start,
  input  wire aau_pkg::aau_op_e   op,
  input  wire aau_pkg::aau_idx_t  dest_index,
  input  wire aau_pkg::aau_word_t dest_value,
  input  wire aau_pkg::aau_word_t src_reg_value,
  input  wire aau_pkg::aau_imm_t  src_imm,
  input  wire logic               src_is_imm,
  input  wire logic               zero_flag_update,
  input  wire logic               carry_flag_update,
  input  wire logic               suppress_writeback,
  output logic                    busy,
  output logic                    done,
  output logic                    wb_en,
  output aau_pkg::aau_idx_t       wb_index,
  output aau_pkg::aau_word_t      wb_data,
  output logic                    zero_flag,
  output logic                    carry_flag
);
  logic       rst_meta_r;
  logic       rst_sync_r;
  aau_state_e state_r;
  aau_op_e    op_r;
  aau_idx_t   idx_r;
  aau_word_t  dst_r;
  aau_word_t  src_r;
  logic       zu_r;
  logic       cu_r;
  logic       sup_r;
  logic       done_r;
  logic       wb_en_r;
  aau_idx_t   wb_index_r;
  aau_word_t  wb_data_r;
  logic       zero_r;
  logic       carry_r;
  logic       accept;
  aau_word_t  src_sel;
  aau_word_t  add_b;
  logic       add_cin;
  logic       src_neg;
  aau_word_t  sum;
  logic       carry_out;
  logic       overflow;
  logic       zero_nxt;
  logic       carry_nxt;

  // Reset released through two flops so deassertion is clean
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign accept = start && (state_r == AAU_ST_IDLE);
  assign busy   = (state_r != AAU_ST_IDLE);

  always_comb
  begin
    if (src_is_imm)
      src_sel = {{(DATA_W-IMM_W){1'b0}}, src_imm};
    else
      src_sel = src_reg_value;
  end

  // Fixed four-step walk regardless of operands or controls
  always_ff @(posedge clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      state_r <= AAU_ST_IDLE;
    else
    begin
      case (state_r)
        AAU_ST_IDLE:   state_r <= accept ? AAU_ST_FETCH : AAU_ST_IDLE;
        AAU_ST_FETCH:  state_r <= AAU_ST_ADD;
        AAU_ST_ADD:    state_r <= AAU_ST_COMMIT;
        AAU_ST_COMMIT: state_r <= AAU_ST_IDLE;
        default:       state_r <= AAU_ST_IDLE;
      endcase
    end
  end

  // Operands captured once; later input changes cannot disturb the operation
  always_ff @(posedge clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      op_r  <= AAU_OP_MAGNITUDE;
      idx_r <= RST_INDEX;
      dst_r <= RST_DATA;
      src_r <= RST_DATA;
      zu_r  <= 1'b0;
      cu_r  <= 1'b0;
      sup_r <= 1'b0;
    end
    else if (accept)
    begin
      op_r  <= op;
      idx_r <= dest_index;
      dst_r <= dest_value;
      src_r <= src_sel;
      zu_r  <= zero_flag_update;
      cu_r  <= carry_flag_update;
      sup_r <= suppress_writeback;
    end
  end

  assign src_neg = (op_r == AAU_OP_MAGNITUDE) && src_r[DATA_W-1];

  always_comb
  begin
    // Negative magnitude source becomes D - S, which equals D + |S|
    add_b   = src_neg ? ~src_r : src_r;
    add_cin = 1'b0;
    if (src_neg)
      add_cin = 1'b1;
    else if (op_r == AAU_OP_SIGNED_CARRY)
      add_cin = carry_r;
  end

  aau_adder u_adder (
    .a         (dst_r),
    .b         (add_b),
    .cin       (add_cin),
    .sum       (sum),
    .carry_out (carry_out),
    .overflow  (overflow)
  );

  always_comb
  begin
    zero_nxt  = zero_r;
    carry_nxt = carry_r;
    case (op_r)
      AAU_OP_MAGNITUDE:
      begin
        if (zu_r)
          zero_nxt = (sum == RST_DATA);
        if (cu_r)
          carry_nxt = src_neg ? ~carry_out : carry_out;
      end
      AAU_OP_SIGNED:
      begin
        if (zu_r)
          zero_nxt = (sum == RST_DATA);
        if (cu_r)
          carry_nxt = overflow;
      end
      default:
      begin
        // Zero chains across words, so an earlier nonzero word sticks
        if (zu_r)
          zero_nxt = zero_r && (sum == RST_DATA);
        if (cu_r)
          carry_nxt = overflow;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      zero_r  <= RST_ZERO;
      carry_r <= RST_CARRY;
    end
    else if (state_r == AAU_ST_COMMIT)
    begin
      zero_r  <= zero_nxt;
      carry_r <= carry_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      done_r     <= 1'b0;
      wb_en_r    <= 1'b0;
      wb_index_r <= RST_INDEX;
      wb_data_r  <= RST_DATA;
    end
    else
    begin
      done_r  <= (state_r == AAU_ST_COMMIT);
      wb_en_r <= (state_r == AAU_ST_COMMIT) && !sup_r;
      if (state_r == AAU_ST_COMMIT)
      begin
        wb_index_r <= idx_r;
        wb_data_r  <= sum;
      end
    end
  end

  assign done       = done_r;
  assign wb_en      = wb_en_r;
  assign wb_index   = wb_index_r;
  assign wb_data    = wb_data_r;
  assign zero_flag  = zero_r;
  assign carry_flag = carry_r;
  // Sums as presented at the taking edge, so the checks can look back at them
  aau_word_t chk_mag_sum;
  aau_word_t chk_add_sum;
  assign chk_mag_sum = dest_value + (src_sel[DATA_W-1] ? (~src_sel + 32'h0000_0001) : src_sel);
  assign chk_add_sum = dest_value + src_sel;

  property p_latency;
    @(posedge clock) disable iff (!rst_sync_r)
    accept |=> busy[*3] ##1 (done && !busy);
  endproperty
  a_latency: assert property (p_latency) else $error("operation not four cycles");

  property p_mag_sum;
    @(posedge clock) disable iff (!rst_sync_r)
    (accept && op == AAU_OP_MAGNITUDE) |-> ##4 wb_data == $past(chk_mag_sum, 4);
  endproperty
  a_mag_sum: assert property (p_mag_sum) else $error("magnitude sum wrong");

  property p_signed_sum;
    @(posedge clock) disable iff (!rst_sync_r)
    (accept && op == AAU_OP_SIGNED) |-> ##4 wb_data == $past(chk_add_sum, 4);
  endproperty
  a_signed_sum: assert property (p_signed_sum) else $error("signed sum wrong");

  property p_imm_zext;
    @(posedge clock) disable iff (!rst_sync_r)
    (accept && src_is_imm) |=> (src_r[DATA_W-1:IMM_W] == 23'h000000);
  endproperty
  a_imm_zext: assert property (p_imm_zext) else $error("immediate not zero-extended");

  property p_suppress;
    @(posedge clock) disable iff (!rst_sync_r)
    accept |-> ##4 (wb_en == !$past(suppress_writeback, 4));
  endproperty
  a_suppress: assert property (p_suppress) else $error("writeback enable wrong");

  property p_dest_index;
    @(posedge clock) disable iff (!rst_sync_r)
    accept |-> ##4 (wb_index == $past(dest_index, 4));
  endproperty
  a_dest_index: assert property (p_dest_index) else $error("writeback index wrong");

  property p_zero_hold;
    @(posedge clock) disable iff (!rst_sync_r)
    (accept && !zero_flag_update) |-> ##4 $stable(zero_flag);
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("zero flag changed");

  property p_carry_hold;
    @(posedge clock) disable iff (!rst_sync_r)
    (accept && !carry_flag_update) |-> ##4 $stable(carry_flag);
  endproperty
  a_carry_hold: assert property (p_carry_hold) else $error("carry flag changed");

  property p_chain_zero;
    @(posedge clock) disable iff (!rst_sync_r)
    (accept && op == AAU_OP_SIGNED_CARRY && zero_flag_update && !zero_flag) |-> ##4 !zero_flag;
  endproperty
  a_chain_zero: assert property (p_chain_zero) else $error("zero chain broken");

  property p_signed_ovf;
    @(posedge clock) disable iff (!rst_sync_r)
    (accept && op == AAU_OP_SIGNED && carry_flag_update) |-> ##4
      carry_flag == (($past(dest_value[31], 4) == $past(src_sel[31], 4))
                     && (wb_data[31] != $past(dest_value[31], 4)));
  endproperty
  a_signed_ovf: assert property (p_signed_ovf) else $error("overflow flag wrong");
endmodule : aau_unit

/* File: testbench/aau_regfile.sv */
// Register file model: supplies the destination operand, takes writebacks
`timescale 1ns/1ps
module aau_regfile
  import aau_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               ld_en,
  input  wire aau_pkg::aau_idx_t  ld_index,
  input  wire aau_pkg::aau_word_t ld_data,
  input  wire logic               wb_en,
  input  wire aau_pkg::aau_idx_t  wb_index,
  input  wire aau_pkg::aau_word_t wb_data,
  input  wire aau_pkg::aau_idx_t  rd_index,
  output aau_pkg::aau_word_t      rd_value
);
  aau_word_t mem [0:(1<<REG_IDX_W)-1];

  // Bench preload never overlaps a writeback
  always_ff @(posedge clock)
  begin
    if (ld_en)
      mem[ld_index] <= ld_data;
    else if (wb_en)
      mem[wb_index] <= wb_data;
  end

  assign rd_value = mem[rd_index];
endmodule : aau_regfile

/* File: testbench/test_abs_and_signed_add_unit.sv */
// Self-checking bench for the absolute and signed add unit
`timescale 1ns/1ps
module test_abs_and_signed_add_unit;
  import aau_pkg::*;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        start = 1'b0;
  aau_op_e     op = AAU_OP_MAGNITUDE;
  aau_idx_t    dest_index = '0;
  aau_word_t   dest_value;
  aau_word_t   src_reg_value = '0;
  aau_imm_t    src_imm = '0;
  logic        src_is_imm = 1'b0;
  logic        zero_flag_update = 1'b0;
  logic        carry_flag_update = 1'b0;
  logic        suppress_writeback = 1'b0;
  logic        ld_en = 1'b0;
  aau_word_t   ld_data = '0;
  logic        busy, done, wb_en, zero_flag, carry_flag;
  aau_idx_t    wb_index;
  aau_word_t   wb_data;
  int          miscompares = 0;
  int          n_checks = 0;
  int          cycles = 0;
  logic [31:0] lfsr = 32'h098A;
  logic        z_m = 1'b0;
  logic        c_m = 1'b0;
  logic [31:0] r1, r2, r3;
  logic [31:0] mag_src [8] = '{32'h4, 32'h3, 32'h2, 32'hFFFF_FFFF, 32'hFFFF_FFFE,
                               32'hFFFF_FFFD, 32'hFFFF_FFFC, 32'h8000_0000};

  aau_unit aau_unit_inst (.clock, .nrst, .start, .op, .dest_index, .dest_value,
    .src_reg_value, .src_imm, .src_is_imm, .zero_flag_update, .carry_flag_update,
    .suppress_writeback, .busy, .done, .wb_en, .wb_index, .wb_data, .zero_flag, .carry_flag);
  aau_regfile aau_regfile_inst (.clock, .ld_en, .ld_index(dest_index), .ld_data, .wb_en,
    .wb_index, .wb_data, .rd_index(dest_index), .rd_value(dest_value));

  always #5 clock = ~clock;

  function automatic logic [31:0] next_rand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : next_rand

  task automatic final_report();
    if (miscompares == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic run(input aau_op_e o, input logic [31:0] d, input logic [31:0] s,
                     input logic imm, input logic zu, input logic cu, input logic sup);
    logic [32:0] sum;
    logic [31:0] sv;
    logic [31:0] res;
    logic [31:0] r;
    logic        neg;
    logic        cy;
    logic        zr;
    int          n;
    sv = imm ? {23'h0, s[8:0]} : s;
    neg = (o == AAU_OP_MAGNITUDE) && sv[31];
    case (o)
      AAU_OP_MAGNITUDE: sum = {1'b0, d} + {1'b0, neg ? -sv : sv};
      AAU_OP_SIGNED: sum = {1'b0, d} + {1'b0, sv};
      default: sum = {1'b0, d} + {1'b0, sv} + {32'h0, c_m};
    endcase
    res = sum[31:0];
    zr = (o == AAU_OP_SIGNED_CARRY) ? (z_m && res == 0) : (res == 0);
    if (o == AAU_OP_MAGNITUDE)
      cy = sum[32] ^ neg;
    else
      cy = (d[31] == sv[31]) && (res[31] != d[31]);
    if (zu)
      z_m = zr;
    if (cu)
      c_m = cy;
    r = next_rand();
    @(posedge clock);
    #1;
    ld_en = 1'b1;
    ld_data = d;
    dest_index = r[8:0];
    @(posedge clock);
    #1;
    ld_en = 1'b0;
    start = 1'b1;
    op = o;
    src_reg_value = imm ? ~s : s;
    src_imm = s[8:0];
    src_is_imm = imm;
    zero_flag_update = zu;
    carry_flag_update = cu;
    suppress_writeback = sup;
    @(posedge clock);
    #1;
    // Start held high into busy and operands disturbed: both must be ignored
    src_reg_value = ~src_reg_value;
    zero_flag_update = ~zu;
    n = 1; // Taking edge is the first of the four cycles
    while (done !== 1'b1 && n < 10)
    begin
      @(posedge clock);
      #1;
      start = 1'b0;
      n++;
      check("busy", busy, n < 4);
    end
    check("latency", n, OP_CYCLES);
    check("wb_en", wb_en, !sup);
    check("wb_index", wb_index, dest_index);
    check("wb_data", wb_data, res);
    check("zero_flag", zero_flag, z_m);
    check("carry_flag", carry_flag, c_m);
    @(posedge clock);
    #1;
    check("done", done, 0);
    check("register", dest_value, sup ? d : res);
  endtask : run

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      final_report();
    end
  end

  initial
  begin
    repeat (6) @(posedge clock);
    #1;
    nrst = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check("reset zero", zero_flag, 0);
    check("reset carry", carry_flag, 0);
    foreach (mag_src[i])
      run(AAU_OP_MAGNITUDE, 32'hFFFF_FFFD, mag_src[i], 0, 1, 1, 0);
    run(AAU_OP_MAGNITUDE, 32'hFFFF_FFFD, 32'h1FF, 1, 1, 1, 0);
    run(AAU_OP_SIGNED, 32'h8000_0000, 32'h8000_0000, 0, 1, 1, 1);
    run(AAU_OP_SIGNED_CARRY, 32'hFFFF_FFFE, 32'h1, 0, 1, 1, 0);
    repeat (200)
    begin
      r1 = next_rand();
      r2 = next_rand();
      r3 = next_rand();
      run(aau_op_e'(2'(r3 % 3)), r1, r2, r3[4], r3[5], r3[6], r3[7]);
    end
    final_report();
  end
endmodule : test_abs_and_signed_add_unit
